// ===== src/usb_evt_defines.svh
// Offsets, bit positions, reset values and timing figures of the USB event flag block
`ifndef USB_EVT_DEFINES_SVH
`define USB_EVT_DEFINES_SVH

// ==========================================
// Register byte offsets
`define EVT_FLAGS_OFFSET 8'h00
`define EVT_ENABLES_OFFSET 8'h04

// ==========================================
// Flag and enable bit positions
`define BIT_BUS_RESET 0
`define BIT_FAULT 1
`define BIT_FRAME_START 2
`define BIT_TRANSACTION_DONE 3
`define BIT_BUS_IDLE 4
`define BIT_WAKEUP 5
`define BIT_UNUSED 6
`define BIT_HALT_SENT 7

// ==========================================
// Reset values and implemented-bit mask
`define EVT_FLAGS_RESET 8'h00
`define EVT_ENABLES_RESET 8'h00
`define EVT_IMPL_MASK 8'hBF

// ==========================================
// Timing figures
`define CLK_PERIOD_NS 20
`define RESET_QUAL_NS 2500
`define WAKEUP_QUAL_NS 2500
`define IDLE_QUAL_NS 3000000

`endif

// ===== src/usb_evt_pkg.sv
// Types shared by the USB event flag block
package usb_evt_pkg;

   // ==========================================
   // Decoded state of the differential pair
   typedef enum logic [1:0] {
      LINE_SE0,
      LINE_J,
      LINE_K,
      LINE_SE1
   } line_state_t;

   // ==========================================
   // Register selected by a bus address
   typedef enum logic [1:0] {
      SEL_FLAGS,
      SEL_ENABLES,
      SEL_NONE
   } reg_sel_t;

endpackage

// ===== src/dur_timer_if.sv
// Condition and qualified-event pair between the flag block and a duration timer
`timescale 1ns/1ps
interface dur_timer_if;
   logic cond; // Condition being timed
   logic fire; // One-cycle pulse once the condition held long enough

   // Side that supplies the condition
   modport owner (output cond, input fire);
   // Side that times it
   modport timer (input cond, output fire);
endinterface

// ===== src/dur_timer.sv
// Counts how long a condition holds and pulses once per episode
`timescale 1ns/1ps
module dur_timer #(
   parameter int CYCLES = 125
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Condition in, event out
   dur_timer_if.timer tif
);

   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] count_q; // Cycles the condition has held
   logic [CW-1:0] count_d;
   logic done_q; // Episode already reported
   logic done_d;
   logic fire_q; // Registered event pulse
   logic fire_d;

   // ==========================================
   // Next state
   always_comb begin
      count_d = count_q;
      done_d = done_q;
      fire_d = 1'b0;
      if (!tif.cond) begin
         // Any break restarts the episode
         count_d = '0;
         done_d = 1'b0;
      end else if (!done_q) begin
         if (count_q == CW'(CYCLES - 1)) begin
            // Held for the full time: report once
            fire_d = 1'b1;
            done_d = 1'b1;
         end else begin
            count_d = count_q + CW'(1);
         end
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
         done_q <= 1'b0;
         fire_q <= 1'b0;
      end else begin
         count_q <= count_d;
         done_q <= done_d;
         fire_q <= fire_d;
      end
   end

   assign tif.fire = fire_q;

endmodule

// ===== src/usb_event_flags.sv
// USB device interrupt flags and enables with a classic Wishbone slave
// How it works
// - Each flag gated by its enable bit.
// - Enabled flags ORed into one interrupt line.
// - Flags stick until software writes one.
// - Flags and enables read zero after reset.
// - Bit 7 sets when halt handshake sent.
// - Bit 5 sets after K for 2.5 us while suspended.
// - Bit 4 sets after 3 ms idle.
// - Any bus activity restarts the idle timer.
// - Bit 3 sets when a transaction completes.
// - Clearing bit 3 advances endpoint status.
// - Bit 2 sets on start-of-frame token.
// - Bit 1 sets on any enabled fault condition.
// - Bit 0 sets after 2.5 us reset.
// - Bus reset reported once per episode.
// - Enable bits sit at flag positions.
// - Fault summary is OR of enabled faults.
`timescale 1ns/1ps
`include "usb_evt_defines.svh"
module usb_event_flags #(
   parameter int IDLE_CYCLES = (`IDLE_QUAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int FAULT_W = 8
) (
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic RESETN_I,
   // Wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // Serial interface engine events, same clock
   input wire logic HALT_SENT_I,
   input wire logic TRANSACTION_DONE_I,
   input wire logic FRAME_START_I,
   input wire logic [FAULT_W-1:0] FAULT_STATUS_I,
   input wire logic [FAULT_W-1:0] FAULT_ENABLE_I,
   // Bus lines, asynchronous
   input wire logic POSITIVE_LINE_I,
   input wire logic NEGATIVE_LINE_I,
   // Results
   output logic IRQ_O,
   output logic STATUS_ADVANCE_O,
   output logic SUSPENDED_O
);

   localparam int RESET_CYCLES = (`RESET_QUAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int WAKEUP_CYCLES = (`WAKEUP_QUAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

   // ==========================================
   // Helpers
   // Address decode
   function automatic usb_evt_pkg::reg_sel_t decode(input logic [7:0] adr);
      usb_evt_pkg::reg_sel_t s;
      s = usb_evt_pkg::SEL_NONE;
      if (adr == `EVT_FLAGS_OFFSET) begin
         s = usb_evt_pkg::SEL_FLAGS;
      end else if (adr == `EVT_ENABLES_OFFSET) begin
         s = usb_evt_pkg::SEL_ENABLES;
      end
      return s;
   endfunction

   // Line state from the synchronised pair
   function automatic usb_evt_pkg::line_state_t line_of(input logic dp, input logic dn);
      usb_evt_pkg::line_state_t l;
      unique case ({dp, dn})
         2'b00: l = usb_evt_pkg::LINE_SE0;
         2'b10: l = usb_evt_pkg::LINE_J;
         2'b01: l = usb_evt_pkg::LINE_K;
         2'b11: l = usb_evt_pkg::LINE_SE1;
      endcase
      return l;
   endfunction

   // ==========================================
   // Line synchronisers
   logic [1:0] dp_sync_q; // Positive line, stage 0 then 1
   logic [1:0] dn_sync_q; // Negative line, stage 0 then 1
   logic [1:0] dp_sync_d;
   logic [1:0] dn_sync_d;
   usb_evt_pkg::line_state_t line; // Decoded line state

   // Shift pins through two stages
   always_comb begin
      dp_sync_d = {dp_sync_q[0], POSITIVE_LINE_I};
      dn_sync_d = {dn_sync_q[0], NEGATIVE_LINE_I};
   end

   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         // Idle J state at reset
         dp_sync_q <= 2'h3;
         dn_sync_q <= 2'h0;
      end else begin
         dp_sync_q <= dp_sync_d;
         dn_sync_q <= dn_sync_d;
      end
   end

   // Only the second stage is decoded
   assign line = line_of(dp_sync_q[1], dn_sync_q[1]);

   // ==========================================
   // Duration timers
   dur_timer_if idle_tif ();
   dur_timer_if reset_tif ();
   dur_timer_if wake_tif ();

   logic suspended_q; // Bus is in suspend
   logic suspended_d;

   // Idle is J; anything else is activity and restarts the count
   assign idle_tif.cond = (line == usb_evt_pkg::LINE_J);
   // Bus reset is SE0 held
   assign reset_tif.cond = (line == usb_evt_pkg::LINE_SE0);
   // Wakeup is K held while suspended
   assign wake_tif.cond = suspended_q && (line == usb_evt_pkg::LINE_K);

   // Idle timer, parameter so a bench can shorten it
   dur_timer #(.CYCLES(IDLE_CYCLES)) u_idle (
      .clk(CLOCK_I),
      .rst_n(RESETN_I),
      .tif(idle_tif.timer)
   );

   // Bus reset qualifier, one pulse per episode
   dur_timer #(.CYCLES(RESET_CYCLES)) u_reset (
      .clk(CLOCK_I),
      .rst_n(RESETN_I),
      .tif(reset_tif.timer)
   );

   // Wakeup qualifier
   dur_timer #(.CYCLES(WAKEUP_CYCLES)) u_wake (
      .clk(CLOCK_I),
      .rst_n(RESETN_I),
      .tif(wake_tif.timer)
   );

   // ==========================================
   // Suspend tracking
   always_comb begin
      suspended_d = suspended_q;
      if (idle_tif.fire) begin
         // Long idle enters suspend
         suspended_d = 1'b1;
      end else if (wake_tif.fire || reset_tif.fire) begin
         // Wakeup or bus reset leaves it
         suspended_d = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         suspended_q <= 1'b0;
      end else begin
         suspended_q <= suspended_d;
      end
   end

   // ==========================================
   // Flags, enables and bus slave
   logic [7:0] flags_q; // Sticky event flags
   logic [7:0] flags_d;
   logic [7:0] enables_q; // Per-flag enables
   logic [7:0] enables_d;
   logic ack_q; // Bus acknowledge
   logic ack_d;
   logic [31:0] rdata_q; // Read data
   logic [31:0] rdata_d;
   logic irq_q; // Interrupt line
   logic irq_d;
   logic advance_q; // Endpoint status advance pulse
   logic advance_d;
   logic [7:0] set_vec; // Events this cycle
   logic [7:0] clr_vec; // Write-one-to-clear mask
   logic access; // New bus request this cycle
   logic wr_lane0; // Write touching the low byte
   usb_evt_pkg::reg_sel_t sel; // Decoded register

   assign access = WB_CYC_I && WB_STB_I && !ack_q;
   assign wr_lane0 = access && WB_WE_I && WB_SEL_I[0];
   assign sel = decode(WB_ADR_I);

   always_comb begin
      // Gather hardware events
      set_vec = 8'h00;
      set_vec[`BIT_HALT_SENT] = HALT_SENT_I;
      set_vec[`BIT_WAKEUP] = wake_tif.fire;
      set_vec[`BIT_BUS_IDLE] = idle_tif.fire;
      set_vec[`BIT_TRANSACTION_DONE] = TRANSACTION_DONE_I;
      set_vec[`BIT_FRAME_START] = FRAME_START_I;
      set_vec[`BIT_FAULT] = |(FAULT_STATUS_I & FAULT_ENABLE_I);
      set_vec[`BIT_BUS_RESET] = reset_tif.fire;

      // Software clear mask, only from a flags write
      clr_vec = 8'h00;
      if (wr_lane0 && sel == usb_evt_pkg::SEL_FLAGS) begin
         clr_vec = WB_DAT_I[7:0];
      end

      // Set wins over clear; bit 6 never stores
      flags_d = ((flags_q & ~clr_vec) | set_vec) & `EVT_IMPL_MASK;

      // Enables write straight through at flag positions
      enables_d = enables_q;
      if (wr_lane0 && sel == usb_evt_pkg::SEL_ENABLES) begin
         enables_d = WB_DAT_I[7:0] & `EVT_IMPL_MASK;
      end

      // Clearing a set done flag advances endpoint status
      advance_d = clr_vec[`BIT_TRANSACTION_DONE] && flags_q[`BIT_TRANSACTION_DONE];

      // Gate each flag by its enable and OR them
      irq_d = |(flags_d & enables_d);

      // One-cycle acknowledge, unmapped reads zero
      ack_d = access;
      rdata_d = rdata_q;
      if (access) begin
         unique case (sel)
            usb_evt_pkg::SEL_FLAGS: rdata_d = {24'h000000, flags_q};
            usb_evt_pkg::SEL_ENABLES: rdata_d = {24'h000000, enables_q};
            usb_evt_pkg::SEL_NONE: rdata_d = 32'h00000000;
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         flags_q <= `EVT_FLAGS_RESET;
         enables_q <= `EVT_ENABLES_RESET;
         ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
         irq_q <= 1'b0;
         advance_q <= 1'b0;
      end else begin
         flags_q <= flags_d;
         enables_q <= enables_d;
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
         advance_q <= advance_d;
      end
   end

   // ==========================================
   // Outputs, all from flip-flops
   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = rdata_q;
   assign IRQ_O = irq_q;
   assign STATUS_ADVANCE_O = advance_q;
   assign SUSPENDED_O = suspended_q;

endmodule

// ===== testbench/usb_event_flags_chk.sv
// Port-level assertions for the USB event flag block
`timescale 1ns/1ps
`include "usb_evt_defines.svh"
module usb_event_flags_chk (
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic RESETN_I,
   // Wishbone side
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   // Results
   input wire logic IRQ_O,
   input wire logic STATUS_ADVANCE_O
);
   // ==========================================
   // Properties
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);
   // Request taken this edge
   sequence s_req;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   // Answer one cycle later
   sequence s_ans;
      ##1 WB_ACK_O;
   endsequence
   property p_irq_rst;
      $rose(RESETN_I) |-> !IRQ_O;
   endproperty
   property p_ack_lat;
      s_req |-> s_ans;
   endproperty
   property p_ack_one;
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   property p_ack_src;
      WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I);
   endproperty
   property p_rd_zero;
      WB_ACK_O && !WB_WE_I |-> WB_DAT_O[31:8] == 24'h000000 && !WB_DAT_O[`BIT_UNUSED];
   endproperty
   property p_adv_src;
      STATUS_ADVANCE_O |-> WB_ACK_O && $past(WB_WE_I && WB_SEL_I[0] && WB_DAT_I[3]
         && WB_ADR_I == `EVT_FLAGS_OFFSET);
   endproperty
   property p_adv_one;
      STATUS_ADVANCE_O |=> !STATUS_ADVANCE_O;
   endproperty
   property p_irq_hold;
      IRQ_O && !(WB_CYC_I && WB_STB_I && WB_WE_I) |=> IRQ_O;
   endproperty
   a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   a_ack_one: assert property (p_ack_one) else $error("ack too long");
   a_ack_src: assert property (p_ack_src) else $error("ack without request");
   a_rd_zero: assert property (p_rd_zero) else $error("unused read bits set");
   a_adv_src: assert property (p_adv_src) else $error("advance without clear");
   a_adv_one: assert property (p_adv_one) else $error("advance too long");
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
endmodule
bind usb_event_flags usb_event_flags_chk chk (
   .CLOCK_I(CLOCK_I),
   .RESETN_I(RESETN_I),
   .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I),
   .WB_ADR_I(WB_ADR_I),
   .WB_SEL_I(WB_SEL_I),
   .WB_DAT_I(WB_DAT_I),
   .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O),
   .IRQ_O(IRQ_O),
   .STATUS_ADVANCE_O(STATUS_ADVANCE_O)
);

// ===== testbench/usb_host_model.sv
// Host model driving the differential pair
`timescale 1ns/1ps
module usb_host_model (
   input wire logic clk_i,
   output logic dp_o,
   output logic dn_o
);
   // Bus starts idle in J
   initial {dp_o, dn_o} = 2'h2;
   // Hold one line state for n cycles
   task automatic drive(input usb_evt_pkg::line_state_t s, input int n);
      {dp_o, dn_o} <= (s == usb_evt_pkg::LINE_J) ? 2'h2 : (s == usb_evt_pkg::LINE_K) ? 2'h1 : 2'h0;
      repeat (n) @(posedge clk_i);
   endtask
endmodule

// ===== testbench/usb_event_flags_tb.sv
// Self-checking bench for the USB event flag block
`timescale 1ns/1ps
`include "usb_evt_defines.svh"
module usb_event_flags_tb;
   // ==========================================
   // Signals
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] dat_o, rd;
   logic ack, irq, adv, susp, dp, dn;
   logic halt = 1'b0, done = 1'b0, sof = 1'b0;
   logic [7:0] fst = 8'h00, fen = 8'hFF;
   logic [3:0] lanes = 4'hF; // Byte enables of the bus master
   int adv_cnt = 0; // Endpoint status advance pulses seen
   int errors = 0;
   int samples_checked = 0;
   always #10 clk = ~clk;
   usb_event_flags #(.IDLE_CYCLES(200), .FAULT_W(8)) dut (.CLOCK_I(clk), .RESETN_I(rst_n),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(lanes),
      .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .HALT_SENT_I(halt),
      .TRANSACTION_DONE_I(done), .FRAME_START_I(sof), .FAULT_STATUS_I(fst),
      .FAULT_ENABLE_I(fen), .POSITIVE_LINE_I(dp), .NEGATIVE_LINE_I(dn), .IRQ_O(irq),
      .STATUS_ADVANCE_O(adv), .SUSPENDED_O(susp));
   usb_host_model host (.clk_i(clk), .dp_o(dp), .dn_o(dn));
   // Count advance pulses, one per high cycle
   always @(posedge clk) begin
      if (adv === 1'b1) begin
         adv_cnt++;
      end
   end
   // ==========================================
   // Helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One classic Wishbone cycle, waits for ack; only the watchdog ends a hang
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      {cyc, stb, we, adr, wdat} <= {2'h3, w, a, 24'h000000, d};
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = dat_o;
      {cyc, stb} <= 2'h0;
      @(posedge clk);
   endtask
   task automatic rdchk(input logic [7:0] a, m, e);
      wb(1'b0, a, 8'h00);
      chk(rd[7:0] & m, e);
   endtask
   // One-cycle event from the engine
   task automatic pulse(input int b);
      {halt, done, sof} <= {b == 7, b == 3, b == 2};
      fst <= {7'h00, b == 1};
      @(posedge clk);
      {halt, done, sof} <= 3'h0;
      fst <= 8'h00;
      @(posedge clk);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      rdchk(`EVT_FLAGS_OFFSET, 8'hFF, 8'h00);
      rdchk(`EVT_ENABLES_OFFSET, 8'hFF, 8'h00);
      wb(1'b1, `EVT_ENABLES_OFFSET, 8'hFF);
      rdchk(`EVT_ENABLES_OFFSET, 8'hFF, 8'hBF);
      // Write without the low byte lane is ignored
      lanes <= 4'hE;
      wb(1'b1, `EVT_ENABLES_OFFSET, 8'h12);
      lanes <= 4'hF;
      rdchk(`EVT_ENABLES_OFFSET, 8'hFF, 8'hBF);
      rdchk(8'h08, 8'hFF, 8'h00);
   endtask
   task automatic t_events();
      int bits[4] = '{7, 3, 2, 1};
      logic [7:0] m;
      foreach (bits[i]) begin
         m = 8'h01 << bits[i];
         wb(1'b1, `EVT_ENABLES_OFFSET, m);
         pulse(bits[i]);
         chk({7'h00, irq}, 8'h01);
         rdchk(`EVT_FLAGS_OFFSET, m, m);
         wb(1'b1, `EVT_FLAGS_OFFSET, 8'h00);
         rdchk(`EVT_FLAGS_OFFSET, m, m);
         wb(1'b1, `EVT_FLAGS_OFFSET, m);
         rdchk(`EVT_FLAGS_OFFSET, m, 8'h00);
         chk({7'h00, irq}, 8'h00);
      end
      // Only the clear of a set done flag advances status
      chk(adv_cnt[7:0], 8'h01);
   endtask
   task automatic t_mask();
      wb(1'b1, `EVT_ENABLES_OFFSET, 8'h00);
      pulse(2);
      chk({7'h00, irq}, 8'h00);
      wb(1'b1, `EVT_ENABLES_OFFSET, 8'h04);
      chk({7'h00, irq}, 8'h01);
      wb(1'b1, `EVT_ENABLES_OFFSET, 8'h00);
      fen <= 8'h00;
      pulse(1);
      rdchk(`EVT_FLAGS_OFFSET, 8'h02, 8'h00);
      fen <= 8'hFF;
   endtask
   task automatic t_line();
      wb(1'b1, `EVT_FLAGS_OFFSET, 8'hBF);
      host.drive(usb_evt_pkg::LINE_SE0, 150);
      rdchk(`EVT_FLAGS_OFFSET, 8'h01, 8'h01);
      wb(1'b1, `EVT_FLAGS_OFFSET, 8'h01);
      host.drive(usb_evt_pkg::LINE_SE0, 200);
      rdchk(`EVT_FLAGS_OFFSET, 8'h01, 8'h00);
      host.drive(usb_evt_pkg::LINE_J, 150);
      rdchk(`EVT_FLAGS_OFFSET, 8'h10, 8'h00);
      host.drive(usb_evt_pkg::LINE_K, 10);
      host.drive(usb_evt_pkg::LINE_J, 150);
      rdchk(`EVT_FLAGS_OFFSET, 8'h10, 8'h00);
      chk({7'h00, susp}, 8'h00);
      host.drive(usb_evt_pkg::LINE_J, 80);
      rdchk(`EVT_FLAGS_OFFSET, 8'h10, 8'h10);
      chk({7'h00, susp}, 8'h01);
      // Wakeup enabled only once idle has been seen
      wb(1'b1, `EVT_ENABLES_OFFSET, 8'h20);
      host.drive(usb_evt_pkg::LINE_K, 140);
      rdchk(`EVT_FLAGS_OFFSET, 8'h20, 8'h20);
      chk({7'h00, irq}, 8'h01);
      chk({7'h00, susp}, 8'h00);
      host.drive(usb_evt_pkg::LINE_SE0, 150);
      rdchk(`EVT_FLAGS_OFFSET, 8'h01, 8'h01);
      chk({7'h00, susp}, 8'h00);
   endtask
   // Reset in mid-run clears flags, enables and outputs
   task automatic t_rerun();
      chk({7'h00, irq}, 8'h01);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk({7'h00, irq}, 8'h00);
      chk({7'h00, susp}, 8'h00);
      rst_n <= 1'b1;
      @(posedge clk);
      rdchk(`EVT_FLAGS_OFFSET, 8'hFF, 8'h00);
      rdchk(`EVT_ENABLES_OFFSET, 8'hFF, 8'h00);
      chk({7'h00, irq}, 8'h00);
   endtask
   // ==========================================
   // Verdict and run control
   task automatic test_done();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #200000;
      errors++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_events();
      t_mask();
      t_line();
      t_rerun();
      test_done();
   end
endmodule
